/* File: hw/acs_tad_gen.sv */
// Bit-period tick generator with minimum-period check.
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_tad_gen
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic rc_tick,
  // Timing out
  output logic tick,
  output logic short_period
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] div_cyc;
  logic is_rc;

  // ==========================================
  // Divisor decode
  always_comb begin
    is_rc = (sel & `ACS_CS_RC_MASK) == `ACS_CS_RC_MASK;
    case (sel)
      `ACS_CS_DIV2: div_cyc = `ACS_DIV2_CYC;
      `ACS_CS_DIV4: div_cyc = `ACS_DIV4_CYC;
      `ACS_CS_DIV8: div_cyc = `ACS_DIV8_CYC;
      `ACS_CS_DIV16: div_cyc = `ACS_DIV16_CYC;
      `ACS_CS_DIV32: div_cyc = `ACS_DIV32_CYC;
      `ACS_CS_DIV64: div_cyc = `ACS_DIV64_CYC;
      default: div_cyc = `ACS_DIV2_CYC;
    endcase
  end

  // ==========================================
  // Counter
  always_comb begin
    cnt_d = cnt_q;
    tick = 1'b0;
    if (!run) begin
      cnt_d = 7'd0;
    end else if (is_rc) begin
      cnt_d = 7'd0;
      tick = rc_tick;
    end else if (cnt_q >= div_cyc - 7'd1) begin
      cnt_d = 7'd0;
      tick = 1'b1;
    end else begin
      cnt_d = cnt_q + 7'd1;
    end
    // minimum period check
    // The RC source never runs faster than the minimum, so it is never short.
    short_period = !is_rc && (div_cyc < `ACS_MIN_TAD_CYC);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 7'd0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: hw/adc_conversion_sequencer.sv */
// Conversion sequencer for a 10-bit successive-approximation converter.
//
// Contract
// - Acquisition is identical before every conversion, whatever resolution is kept.
// - Bits converted after the period drops below minimum are marked invalid.
// - Conversion time is one period, N periods, then remaining periods at 2 Tosc; here all twelve periods run at the selected rate.
// - Each completed conversion loads the 10-bit result into the 16-bit pair.
// - Align select places the result left or right; six spare bits are zero.
// - With the module off both result bytes are plain writable registers.
// - Conversion in sleep only works with the RC clock selected.
// - With RC selected the start waits one instruction cycle.
// - Completion clears the start bit and writes the result pair.
// - Completion in sleep with interrupt enabled raises done and wakes.
// - Completion in sleep with interrupt off powers down; power-on bit stays.
// - Sleep with a non-RC clock aborts and powers down; power-on bit stays.
// - Reset restores registers, turns the module off and aborts conversion.
// - After reset analog-shared pins are analog with direction set to input.
// - Power-on reset leaves the result pair undefined.
// - Channel may change once the hold capacitor disconnects after start.
// - The minimum supported bit period is 1.6 us.
// - Clock select codes give 2,4,8,16,32,64 Tosc or RC.
// - Clearing start mid-conversion aborts, keeps result, waits two periods.
// - A full conversion takes about twelve bit periods.
// - After completion the capacitor stays disconnected for two periods.
`timescale 1ns/1ps
`include "acs_defs.svh"
module adc_conversion_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control bits
  input wire logic converter_power_on,
  input wire logic [2:0] conv_clock_select,
  input wire logic result_align_select,
  input wire logic conv_done_irq_enable,
  input wire logic start_set,
  input wire logic start_clear,
  input wire logic sleep_entry,
  // Result byte writes
  input wire logic upper_wr,
  input wire logic lower_wr,
  input wire logic [7:0] wr_data,
  // Pin configuration writes
  input wire logic pin_cfg_wr,
  input wire logic [15:0] pin_analog_in,
  input wire logic [15:0] pin_dir_in,
  // Analog front end
  input wire logic rc_tick,
  input wire logic cmp_high,
  output logic hold_connect,
  output logic [9:0] sar_trial,
  // Status and results
  output logic conv_busy,
  output logic conv_done,
  output logic wake_req,
  output logic module_powered,
  output logic [9:0] invalid_bits,
  output logic [7:0] result_upper_byte,
  output logic [7:0] result_lower_byte,
  output logic [15:0] pin_analog,
  output logic [15:0] port_direction_bit
);
  acs_state_e state_q, state_d;
  logic [3:0] step_q, step_d;
  logic [2:0] wait_q, wait_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic wake_q, wake_d;
  logic hold_q, hold_d;
  logic powered_q, powered_d;
  logic short_seen_q, short_seen_d;
  logic [9:0] sar_q, sar_d;
  logic [9:0] inv_q, inv_d;
  logic [15:0] pin_an_q, pin_an_d;
  logic [15:0] pin_dir_q, pin_dir_d;
  acs_result_s res_q, res_d;
  acs_result_s res_load;
  logic is_rc;
  logic tad_run;
  logic tad_tick;
  logic tad_short;
  logic bit_step;
  logic [3:0] bit_idx;
  logic finish;

  assign is_rc = (conv_clock_select & `ACS_CS_RC_MASK) == `ACS_CS_RC_MASK;
  // restart the divider
  // An abort stops the divider for one cycle, so the hold after it spans two whole periods.
  assign tad_run = ((state_q == ST_CONV) && !start_clear) || (state_q == ST_HOLD);

  acs_tad_gen u_tad (
    .clk(clk),
    .nrst(nrst),
    .run(tad_run),
    .sel(conv_clock_select),
    .rc_tick(rc_tick),
    .tick(tad_tick),
    .short_period(tad_short)
  );

  // ==========================================
  // Successive approximation per bit
  assign bit_step = (state_q == ST_CONV) && tad_tick && (step_q >= 4'd1) && (step_q <= 4'd10);
  assign bit_idx = 4'd10 - step_q;
  assign finish = (state_q == ST_CONV) && tad_tick && (step_q == `ACS_LAST_STEP);

  genvar b;
  generate
    for (b = 0; b < 10; b++) begin : g_bit
      always_comb begin
        sar_d[b] = sar_q[b];
        inv_d[b] = inv_q[b];
        if ((state_q != ST_CONV) && (state_d == ST_CONV)) begin
          sar_d[b] = (b == 9);
          inv_d[b] = 1'b0;
        end else if (bit_step && (bit_idx == 4'(b))) begin
          sar_d[b] = cmp_high;
          inv_d[b] = short_seen_q || tad_short;
        end else if (bit_step && (bit_idx == 4'(b + 1))) begin
          sar_d[b] = 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================
  // Result justification
  always_comb begin
    // zero fill of spare bits
    // The last bit is decided one tick before the load, so the trial word already holds the result.
    if (result_align_select) begin
      res_load = {6'h00, sar_q};
    end else begin
      res_load = {sar_q, 6'h00};
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    wait_d = wait_q;
    busy_d = busy_q;
    done_d = 1'b0;
    wake_d = 1'b0;
    short_seen_d = short_seen_q;
    if (tad_tick && (state_q == ST_CONV) && tad_short) begin
      short_seen_d = 1'b1;
    end
    case (state_q)
      ST_OFF: begin
        busy_d = 1'b0;
        if (converter_power_on) begin
          state_d = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (sleep_entry && !is_rc) begin
          state_d = ST_PDN;
        end else if (start_set) begin
          busy_d = 1'b1;
          step_d = 4'd0;
          wait_d = 3'd0;
          short_seen_d = 1'b0;
          state_d = is_rc ? ST_DLY : ST_CONV;
        end
      end
      ST_DLY: begin
        if (start_clear) begin
          busy_d = 1'b0;
          step_d = 4'd0;
          state_d = ST_HOLD;
        end else if (wait_q == `ACS_INSTR_CYC - 3'd1) begin
          state_d = ST_CONV;
        end else begin
          wait_d = wait_q + 3'd1;
        end
      end
      ST_CONV: begin
        if (sleep_entry && !is_rc) begin
          // abort on sleep with an oscillator clock
          busy_d = 1'b0;
          state_d = ST_PDN;
        end else if (start_clear) begin
          busy_d = 1'b0;
          step_d = 4'd0;
          state_d = ST_HOLD;
        end else if (finish) begin
          // clear start and post the event
          busy_d = 1'b0;
          done_d = 1'b1;
          step_d = 4'd0;
          state_d = ST_HOLD;
          // sleep conversion only reaches here on RC
          if (sleep_entry) begin
            wake_d = conv_done_irq_enable;
            if (!conv_done_irq_enable) begin
              state_d = ST_PDN;
            end
          end
        end else if (tad_tick) begin
          // one tick per bit period at the current rate
          step_d = step_q + 4'd1;
        end
      end
      ST_HOLD: begin
        if (tad_tick) begin
          if (step_q == `ACS_HOLD_TADS - 4'd1) begin
            state_d = ST_ACQ;
          end else begin
            step_d = step_q + 4'd1;
          end
        end
      end
      ST_PDN: begin
        busy_d = 1'b0;
        if (!sleep_entry) begin
          state_d = ST_ACQ;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!converter_power_on) begin
      state_d = ST_OFF;
      busy_d = 1'b0;
    end
    // disconnect at start, inside the hold window
    hold_d = (state_d == ST_ACQ);
    powered_d = (state_d != ST_OFF) && (state_d != ST_PDN);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_OFF;
      step_q <= 4'd0;
      wait_q <= 3'd0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      wake_q <= 1'b0;
      hold_q <= 1'b0;
      powered_q <= 1'b0;
      short_seen_q <= 1'b0;
      sar_q <= 10'h000;
      inv_q <= 10'h000;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      wait_q <= wait_d;
      busy_q <= busy_d;
      done_q <= done_d;
      wake_q <= wake_d;
      hold_q <= hold_d;
      powered_q <= powered_d;
      short_seen_q <= short_seen_d;
      sar_q <= sar_d;
      inv_q <= inv_d;
    end
  end

  // ==========================================
  // Result pair and pin configuration
  always_comb begin
    res_d = res_q;
    if (finish && !start_clear && !(sleep_entry && !is_rc) && converter_power_on) begin
      res_d = res_load;
    end else if (state_q == ST_OFF) begin
      if (upper_wr) begin
        res_d.upper = wr_data;
      end
      if (lower_wr) begin
        res_d.lower = wr_data;
      end
    end
    pin_an_d = pin_cfg_wr ? pin_analog_in : pin_an_q;
    pin_dir_d = pin_cfg_wr ? pin_dir_in : pin_dir_q;
  end

  // no reset on the result pair
  // Leaving it unreset matches the undefined content software must expect.
  always_ff @(posedge clk) begin
    res_q <= res_d;
  end

  // pins come up analog and input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_an_q <= `ACS_PINS_RESET;
      pin_dir_q <= `ACS_PINS_RESET;
    end else begin
      pin_an_q <= pin_an_d;
      pin_dir_q <= pin_dir_d;
    end
  end

  assign conv_done = done_q;
  assign wake_req = wake_q;
  assign conv_busy = busy_q;
  assign hold_connect = hold_q;
  assign sar_trial = sar_q;
  assign invalid_bits = inv_q;
  assign module_powered = powered_q;
  assign result_upper_byte = res_q.upper;
  assign result_lower_byte = res_q.lower;
  assign pin_analog = pin_an_q;
  assign port_direction_bit = pin_dir_q;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_done_clears_busy: assert property (conv_done |-> !conv_busy && state_q != ST_CONV)
    else $error("busy still set at completion");
  chk_result_align: assert property (conv_done |-> ($past(result_align_select) ?
    result_upper_byte[7:2] == 6'h00 : result_lower_byte[5:0] == 6'h00))
    else $error("spare result bits not zero");
  chk_sleep_abort: assert property ((state_q == ST_CONV && sleep_entry && !is_rc &&
    converter_power_on) |=> state_q == ST_PDN && !conv_busy)
    else $error("no abort on sleep with oscillator clock");
  chk_rc_start_delay: assert property ((state_q == ST_ACQ && start_set && is_rc &&
    converter_power_on && !start_clear) |=> state_q == ST_DLY ##1 state_q == ST_DLY)
    else $error("rc start not delayed");
  chk_wake_on_done: assert property (wake_req |-> conv_done && $past(conv_done_irq_enable))
    else $error("wake without enabled completion");
  chk_sleep_pdn: assert property ((conv_done && !wake_req && $past(sleep_entry)) |->
    state_q == ST_PDN && !module_powered)
    else $error("module not powered down after sleep completion");
  chk_abort_keeps: assert property ((state_q == ST_CONV && start_clear && converter_power_on &&
    !(sleep_entry && !is_rc)) |=> state_q == ST_HOLD && !conv_done)
    else $error("abort did not go to hold");
  chk_hold_two_tad: assert property ((state_q == ST_HOLD && tad_tick && step_q == 4'd1 &&
    converter_power_on) |=> state_q == ST_ACQ)
    else $error("hold not two periods");
  chk_step_bound: assert property (state_q == ST_CONV |-> step_q <= `ACS_LAST_STEP)
    else $error("conversion ran past its last step");
  chk_hold_open: assert property ((state_q != ST_CONV ##1 state_q == ST_CONV) |-> !hold_connect)
    else $error("capacitor still connected in conversion");
  chk_short_marks: assert property ((bit_step && tad_short) |=> inv_q[$past(bit_idx)])
    else $error("short period bit not flagged");

  cov_full_conv: cover property (state_q == ST_CONV ##1 conv_done);
  cov_sleep_wake: cover property (wake_req);
  cov_abort: cover property (state_q == ST_CONV && start_clear);
  cov_pdn: cover property (state_q == ST_CONV ##1 state_q == ST_PDN);
endmodule

/* File: inc/acs_defs.svh */
// Constants for the converter sequencer: encodings, field positions and timing counts.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// ==========================================
// Clock selection codes and divisor counts
`define ACS_CS_DIV2 3'b000
`define ACS_CS_DIV4 3'b100
`define ACS_CS_DIV8 3'b001
`define ACS_CS_DIV16 3'b101
`define ACS_CS_DIV32 3'b010
`define ACS_CS_DIV64 3'b110
`define ACS_CS_RC_MASK 3'b011
`define ACS_DIV2_CYC 7'd2
`define ACS_DIV4_CYC 7'd4
`define ACS_DIV8_CYC 7'd8
`define ACS_DIV16_CYC 7'd16
`define ACS_DIV32_CYC 7'd32
`define ACS_DIV64_CYC 7'd64
// ==========================================
// Timing
`define ACS_CLK_NS 50
`define ACS_MIN_TAD_NS 1600
`define ACS_MIN_TAD_CYC 7'((`ACS_MIN_TAD_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_INSTR_CYC 3'd4
`define ACS_HOLDCAP_NS 100
`define ACS_HOLDCAP_CYC (`ACS_HOLDCAP_NS / `ACS_CLK_NS)
`define ACS_LAST_STEP 4'd11
`define ACS_HOLD_TADS 4'd2
// ==========================================
// Result layout and reset values
`define ACS_FIRST_TRIAL 10'h200
`define ACS_PINS_RESET 16'hFFFF
`endif

/* File: inc/acs_pkg.sv */
// Types shared by the converter sequencer modules.
package acs_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_DLY, ST_CONV, ST_HOLD, ST_PDN} acs_state_e;
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } acs_result_s;
endpackage

/* File: tb/test_adc_conversion_sequencer.sv */
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
  import acs_pkg::*;
  // ==========================================
  // Signals
  logic clk, nrst, converter_power_on, result_align_select, conv_done_irq_enable;
  logic start_set, start_clear, sleep_entry, upper_wr, lower_wr, pin_cfg_wr, rc_tick, cmp_high;
  logic [2:0] conv_clock_select;
  logic [7:0] wr_data, result_upper_byte, result_lower_byte;
  logic [15:0] pin_analog_in, pin_dir_in, pin_analog, port_direction_bit, last_res;
  logic hold_connect, conv_busy, conv_done, wake_req, module_powered;
  logic [9:0] sar_trial, invalid_bits, ain;
  logic [26:0] expq[$];
  int errors, comparisons, rc_cnt;

  adc_conversion_sequencer DUT (.clk(clk), .nrst(nrst), .converter_power_on(converter_power_on),
    .conv_clock_select(conv_clock_select), .result_align_select(result_align_select),
    .conv_done_irq_enable(conv_done_irq_enable), .start_set(start_set), .start_clear(start_clear),
    .sleep_entry(sleep_entry), .upper_wr(upper_wr), .lower_wr(lower_wr), .wr_data(wr_data),
    .pin_cfg_wr(pin_cfg_wr), .pin_analog_in(pin_analog_in), .pin_dir_in(pin_dir_in),
    .rc_tick(rc_tick), .cmp_high(cmp_high), .hold_connect(hold_connect), .sar_trial(sar_trial),
    .conv_busy(conv_busy), .conv_done(conv_done), .wake_req(wake_req),
    .module_powered(module_powered), .invalid_bits(invalid_bits),
    .result_upper_byte(result_upper_byte), .result_lower_byte(result_lower_byte),
    .pin_analog(pin_analog), .port_direction_bit(port_direction_bit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // Analog side: the comparator follows a fixed input level, and the RC
  // oscillator ticks every five clocks, unrelated to any divider.
  always @(negedge clk) begin
    cmp_high <= (sar_trial <= ain);
    rc_cnt <= rc_cnt + 1;
    rc_tick <= (rc_cnt % 5 == 0);
  end

  // ==========================================
  // Checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Every completion must match the oldest note left by the driver.
  always @(negedge clk) begin
    if (conv_done === 1'b1) begin
      if (expq.size() == 0)
        check(1, 0);
      else
        check({wake_req, invalid_bits, result_upper_byte, result_lower_byte}, expq.pop_front());
      check(conv_busy, 0);
    end
  end

  initial begin
    #(40000 * 50);
    errors++;
    tally_and_finish();
  end

  // ==========================================
  // Driver helpers
  function automatic int div_of(input logic [2:0] sel);
    case (sel)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return 5;
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_acq(output int n);
    n = 0;
    while (hold_connect !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) check(0, 1);
  endtask

  task automatic pulse_start;
    start_set = 1'b1;
    @(negedge clk);
    start_set = 1'b0;
  endtask

  task automatic convert(input logic [2:0] sel, input logic al, input logic irq, input logic slp);
    int n, d;
    logic [15:0] r;
    logic [9:0] inv;
    conv_clock_select = sel;
    result_align_select = al;
    conv_done_irq_enable = irq;
    wait_acq(n);
    ain = 10'($urandom);
    r = al ? {6'h00, ain} : {ain, 6'h00};
    d = div_of(sel);
    inv = (sel[1:0] != 2'b11 && d < 32) ? 10'h3FF : 10'h000;
    expq.push_back({slp & irq, inv, r});
    last_res = r;
    pulse_start();
    check(hold_connect, 0);
    sleep_entry = slp;
    n = 1;
    while (conv_done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (sel[1:0] != 2'b11) check(n, 12 * d + 1);
    else check(n >= 61 && n <= 65, 1);
    if (slp && !irq) begin
      cyc(2);
      check(module_powered, 0);
    end
    sleep_entry = 1'b0;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    int n;
    logic [15:0] w;
    {nrst, converter_power_on, result_align_select, conv_done_irq_enable} = 4'h0;
    {start_set, start_clear, sleep_entry, upper_wr, lower_wr, pin_cfg_wr} = 6'h00;
    conv_clock_select = 3'h0;
    wr_data = 8'h00;
    pin_analog_in = 16'h0000;
    pin_dir_in = 16'h0000;
    ain = 10'h000;
    errors = 0;
    comparisons = 0;
    void'($urandom(32'h80b8));
    cyc(10);
    check({pin_analog, port_direction_bit}, 32'hFFFFFFFF);
    nrst = 1'b1;
    cyc(2);
    // Module off: the result bytes are plain storage.
    w = 16'($urandom);
    upper_wr = 1'b1;
    wr_data = w[15:8];
    @(negedge clk);
    upper_wr = 1'b0;
    lower_wr = 1'b1;
    wr_data = w[7:0];
    @(negedge clk);
    lower_wr = 1'b0;
    @(negedge clk);
    check({result_upper_byte, result_lower_byte}, w);
    converter_power_on = 1'b1;
    wait_acq(n);
    upper_wr = 1'b1;
    wr_data = ~w[15:8];
    @(negedge clk);
    upper_wr = 1'b0;
    @(negedge clk);
    check(result_upper_byte, w[15:8]);
    // Every clock-select code, random alignment.
    for (int i = 0; i < 8; i++) convert(3'(i), 1'($urandom), 1'b0, 1'b0);
    convert(3'h7, 1'b0, 1'b1, 1'b1);
    convert(3'h3, 1'b1, 1'b0, 1'b1);
    convert(3'h2, 1'b0, 1'b1, 1'b0);
    // Software abort keeps the old result and waits two bit periods.
    conv_clock_select = 3'h1;
    wait_acq(n);
    pulse_start();
    cyc(20);
    start_clear = 1'b1;
    @(negedge clk);
    start_clear = 1'b0;
    wait_acq(n);
    check(n, 2 * div_of(3'h1));
    check({conv_busy, result_upper_byte, result_lower_byte}, {1'b0, last_res});
    // Sleep with an oscillator divider aborts and powers down.
    conv_clock_select = 3'h2;
    wait_acq(n);
    pulse_start();
    cyc(40);
    sleep_entry = 1'b1;
    cyc(3);
    check({conv_busy, module_powered, result_upper_byte, result_lower_byte}, {2'b00, last_res});
    sleep_entry = 1'b0;
    // Pin setup, then a reset in mid-conversion.
    pin_analog_in = 16'($urandom);
    pin_dir_in = 16'($urandom);
    pin_cfg_wr = 1'b1;
    @(negedge clk);
    pin_cfg_wr = 1'b0;
    @(negedge clk);
    check({pin_analog, port_direction_bit}, {pin_analog_in, pin_dir_in});
    conv_clock_select = 3'h0;
    wait_acq(n);
    pulse_start();
    cyc(5);
    nrst = 1'b0;
    cyc(2);
    check({conv_busy, module_powered, pin_analog, port_direction_bit}, {2'b00, 32'hFFFFFFFF});
    nrst = 1'b1;
    cyc(40);
    check(expq.size(), 0);
    tally_and_finish();
  end
endmodule
